// ==== verilog/cbt_pkg.sv ====
package cbt_pkg;
	// =====================================================
	// timing
	localparam int CBT_CLK_HZ   = 40_000_000;
	localparam int CBT_SEQ_HZ   = 1_000_000;
	localparam int CBT_SEQ_DIV  = CBT_CLK_HZ / CBT_SEQ_HZ;
	// =====================================================
	// acquisition figures
	localparam int CBT_CNT_W    = 16;
	localparam int CBT_WIN      = 256;
	localparam int CBT_AVG_N    = 44;
	localparam int CBT_NCS      = 8;
	localparam int CBT_COMP_W   = 8;
	localparam logic [15:0] CBT_GAIN_0 = 16'h0400;
	localparam logic [15:0] CBT_GAIN_1 = 16'h0600;
	localparam logic [15:0] CBT_GAIN_2 = 16'h0800;
	localparam logic [15:0] CBT_GAIN_3 = 16'h0A00;
	// =====================================================
	// register offsets
	localparam logic [7:0] CBT_A_CTRL   = 8'h00;
	localparam logic [7:0] CBT_A_TARGET = 8'h04;
	localparam logic [7:0] CBT_A_PROX   = 8'h08;
	localparam logic [7:0] CBT_A_TOUCH  = 8'h0C;
	localparam logic [7:0] CBT_A_STATUS = 8'h10;
	localparam logic [7:0] CBT_A_COUNT  = 8'h14;
	localparam logic [7:0] CBT_A_IRQ_ST = 8'h18;
	localparam logic [7:0] CBT_A_IRQ_CL = 8'h1C;
	localparam logic [7:0] CBT_A_IRQ_EN = 8'h20;
	// =====================================================
	// fields and reset values
	localparam int CBT_F_MODE   = 0;
	localparam int CBT_F_GAIN   = 2;
	localparam int CBT_F_RETUNE = 4;
	localparam int CBT_F_PP     = 5;
	localparam logic [1:0] CBT_MODE_CTRL   = 2'h0;
	localparam logic [1:0] CBT_MODE_DUAL   = 2'h1;
	localparam logic [1:0] CBT_MODE_STREAM = 2'h2;
	localparam logic [5:0]  CBT_CTRL_RST   = 6'h00;
	localparam logic [15:0] CBT_TARGET_RST = 16'h0500;
	localparam logic [15:0] CBT_PROX_RST   = 16'h0010;
	localparam logic [15:0] CBT_TOUCH_RST  = 16'h0040;
	localparam int CBT_NIRQ = 4;
	localparam int CBT_I_TUNED = 0;
	localparam int CBT_I_PROX  = 1;
	localparam int CBT_I_TOUCH = 2;
	localparam int CBT_I_SAT   = 3;
	typedef enum logic [2:0] {ST_IDLE, ST_CS, ST_COMP, ST_AVG, ST_RUN} cbt_state_t;
	typedef enum logic [1:0] {B_IDLE, B_CHG, B_XFR} cbt_phase_t;
endpackage

// ==== verilog/cbt_burst.sv ====
module cbt_burst
	import cbt_pkg::*;
#(
	parameter int CNT_W = CBT_CNT_W
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             tick,
	input  wire logic             start,
	input  wire logic             trip,
	output logic                  charge_on,
	output logic                  transfer_on,
	output logic                  busy,
	output logic                  done,
	output logic [CNT_W-1:0]      count,
	output logic                  sat
);
	if (CNT_W < 8 || CNT_W > 16) begin : g_bad_width
		$error("count width unsupported");
	end

	localparam logic [CNT_W-1:0] MAXC = '1;
	cbt_phase_t       ph_q;
	logic [CNT_W-1:0] cnt_q;
	logic             done_q;
	logic             sat_q;
	wire  [CNT_W-1:0] cnt_inc = cnt_q + 1'b1;
	wire              at_max  = (cnt_inc == MAXC);
	wire              finish  = (ph_q == B_XFR) && tick && (trip || at_max);

	// =====================================================
	// charge then transfer, one period per tick pair
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_q   <= B_IDLE;
			cnt_q  <= '0;
			done_q <= 1'b0;
			sat_q  <= 1'b0;
		end else begin
			done_q <= finish;
			unique case (ph_q)
				B_IDLE: if (start) begin
					cnt_q <= '0;
					sat_q <= 1'b0;
					ph_q  <= B_CHG;
				end
				B_CHG: if (tick) ph_q <= B_XFR;
				B_XFR: if (tick) begin
					cnt_q <= cnt_inc;
					// a dead electrode never trips: stop at full scale
					if (finish) begin
						sat_q <= at_max && !trip;
						ph_q  <= B_IDLE;
					end else
						ph_q <= B_CHG;
				end
			endcase
		end
	end

	assign charge_on   = (ph_q == B_CHG);
	assign transfer_on = (ph_q == B_XFR);
	assign busy        = (ph_q != B_IDLE);
	assign done        = done_q;
	assign count       = cnt_q;
	assign sat         = sat_q;

	sequence xfr_end_s;
		ph_q == B_XFR && tick && (trip || at_max);
	endsequence

	done_follows_a: assert property (@(posedge clk) disable iff (!rst_n)
		xfr_end_s |=> done && !busy)
		else $error("burst end not reported");
	count_sat_a: assert property (@(posedge clk) disable iff (!rst_n)
		busy |-> cnt_q != MAXC)
		else $error("burst ran past full scale");
endmodule // cbt_burst

// ==== verilog/cbt_tuning.sv ====
// The register offsets and the AHB-Lite register port are this design's own decisions.
module cbt_tuning
	import cbt_pkg::*;
(
	input  wire logic                  hclk,
	input  wire logic                  hresetn,
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic                       hreadyout,
	output logic                       hresp,
	output logic [31:0]                hrdata,
	input  wire logic                  trip_level,
	output logic                       charge_on,
	output logic                       transfer_on,
	output logic [2:0]                 cs_sel,
	output logic [CBT_COMP_W-1:0]      parasitic_compensation,
	output logic                       primary_o,
	output logic                       primary_oe,
	input  wire logic                  secondary_i,
	output logic                       secondary_o,
	output logic                       secondary_oe,
	output logic                       irq
);
	localparam int CW = CBT_CNT_W;
	localparam logic [CBT_COMP_W-1:0] COMP_MAX = '1;
	localparam logic [2:0] CS_LAST = 3'(CBT_NCS - 1);
	localparam logic [5:0] AVG_LAST = 6'(CBT_AVG_N - 1);
	localparam logic [5:0] DIV_W = 6'(CBT_SEQ_DIV - 1);
	localparam logic [CW:0] WIN = (CW+1)'(CBT_WIN);

	// =====================================================
	// sequencing tick and pin synchronisers
	logic [5:0] div_q;
	logic       tick;
	logic [1:0] trip_sq;
	logic [1:0] sec_sq;
	logic       sec_prev_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_q      <= '0;
			trip_sq    <= '0;
			sec_sq     <= '0;
			sec_prev_q <= 1'b0;
		end else begin
			div_q      <= tick ? 6'h00 : div_q + 6'h01;
			trip_sq    <= {trip_sq[0], trip_level};
			sec_sq     <= {sec_sq[0], secondary_i};
			sec_prev_q <= sec_sq[1];
		end
	end
	assign tick = (div_q == DIV_W);

	// =====================================================
	// register bus
	logic        ap_wr_q;
	logic [7:0]  ap_a_q;
	logic [5:0]  ctrl_q;
	logic [15:0] target_q;
	logic [15:0] prox_th_q;
	logic [15:0] touch_th_q;
	logic [CBT_NIRQ-1:0] ist_q;
	logic [CBT_NIRQ-1:0] ien_q;
	logic [CBT_NIRQ-1:0] ev;
	logic [31:0] rd_mux;

	wire        ap_take   = hsel && hready && htrans[1];
	wire        wr_ctrl   = ap_wr_q && ap_a_q == CBT_A_CTRL;
	wire        wr_clr    = ap_wr_q && ap_a_q == CBT_A_IRQ_CL;
	wire [1:0]  mode      = ctrl_q[CBT_F_MODE +: 2];
	wire [1:0]  gain_sel  = ctrl_q[CBT_F_GAIN +: 2];
	wire        pp        = ctrl_q[CBT_F_PP];
	wire        sw_retune = wr_ctrl && hwdata[CBT_F_RETUNE];
	// in control mode a rising edge on the host control input asks for a retune
	wire        host_retune = (mode == CBT_MODE_CTRL) && sec_sq[1] && !sec_prev_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_wr_q <= 1'b0;
			ap_a_q  <= '0;
			hrdata  <= '0;
		end else begin
			ap_wr_q <= ap_take && hwrite;
			ap_a_q  <= {haddr[7:2], 2'b00};
			hrdata  <= (ap_take && !hwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_q     <= CBT_CTRL_RST;
			target_q   <= CBT_TARGET_RST;
			prox_th_q  <= CBT_PROX_RST;
			touch_th_q <= CBT_TOUCH_RST;
			ien_q      <= '0;
		end else if (ap_wr_q) begin
			// retune is a strobe, never stored
			if (ap_a_q == CBT_A_CTRL)
				ctrl_q <= {hwdata[CBT_F_PP], 1'b0, hwdata[CBT_F_GAIN +: 2], hwdata[CBT_F_MODE +: 2]};
			if (ap_a_q == CBT_A_TARGET) target_q <= hwdata[15:0];
			if (ap_a_q == CBT_A_PROX) prox_th_q <= hwdata[15:0];
			if (ap_a_q == CBT_A_TOUCH) touch_th_q <= hwdata[15:0];
			if (ap_a_q == CBT_A_IRQ_EN) ien_q <= hwdata[CBT_NIRQ-1:0];
		end
	end

	// the event of the clearing cycle survives: set wins over clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			ist_q <= '0;
		else
			ist_q <= (ist_q & ~(wr_clr ? hwdata[CBT_NIRQ-1:0] : '0)) | ev;
	end
	assign irq       = |(ist_q & ien_q);
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// =====================================================
	// burst engine
	cbt_state_t      st_q;
	logic            b_start;
	logic            b_busy;
	logic            b_done;
	logic            b_sat;
	logic [CW-1:0]   b_cnt;
	cbt_burst #(.CNT_W(CW)) u_burst (
		.clk         (hclk),
		.rst_n       (hresetn),
		.tick        (tick),
		.start       (b_start),
		.trip        (trip_sq[1]),
		.charge_on   (charge_on),
		.transfer_on (transfer_on),
		.busy        (b_busy),
		.done        (b_done),
		.count       (b_cnt),
		.sat         (b_sat)
	);

	// =====================================================
	// tuning sequencer
	logic [2:0]            cs_q;
	logic [2:0]            best_cs_q;
	logic [CW-1:0]         best_d_q;
	logic [CBT_COMP_W-1:0] comp_q;
	logic [5:0]            avg_n_q;
	logic [CW+5:0]         sum_q;
	logic [CW-1:0]         ref_q;
	logic [CW-1:0]         last_q;
	logic                  prox_q;
	logic                  touch_q;
	logic [15:0]           gain_tgt;

	always_comb begin
		unique case (gain_sel)
			2'h0: gain_tgt = CBT_GAIN_0;
			2'h1: gain_tgt = CBT_GAIN_1;
			2'h2: gain_tgt = CBT_GAIN_2;
			2'h3: gain_tgt = CBT_GAIN_3;
		endcase
	end

	wire [CW-1:0] g_dist    = (b_cnt > gain_tgt) ? b_cnt - gain_tgt : gain_tgt - b_cnt;
	wire          better    = (cs_q == 3'h0) || (g_dist < best_d_q);
	wire [2:0]    pick_cs   = better ? cs_q : best_cs_q;
	wire [CW:0]   win_hi    = {1'b0, target_q} + WIN;
	wire [CW:0]   win_lo    = (target_q > CBT_WIN) ? {1'b0, target_q} - WIN : '0;
	wire          in_upper  = {1'b0, b_cnt} <= win_hi;
	wire [CW+5:0] sum_nx    = sum_q + (CW+6)'(b_cnt);
	wire [CW+5:0] avg_val   = sum_nx / (CW+6)'(CBT_AVG_N);
	wire          ref_out   = {1'b0, ref_q} > win_hi || {1'b0, ref_q} < win_lo;
	wire [CW-1:0] delta     = (ref_q > b_cnt) ? ref_q - b_cnt : '0;
	wire          prox_nx   = delta > prox_th_q;
	wire          touch_nx  = delta > touch_th_q;
	wire          run_done  = (st_q == ST_RUN) && b_done;
	wire          retune    = sw_retune || host_retune || (run_done && ref_out);
	wire          tuning    = (st_q != ST_RUN);

	assign b_start = !b_busy && !b_done && (st_q != ST_IDLE);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q      <= ST_IDLE;
			cs_q      <= '0;
			best_cs_q <= '0;
			best_d_q  <= '0;
			comp_q    <= '0;
			avg_n_q   <= '0;
			sum_q     <= '0;
			ref_q     <= '0;
		end else if (retune || st_q == ST_IDLE) begin
			st_q   <= ST_CS;
			cs_q   <= '0;
			comp_q <= '0;
		end else if (b_done) begin
			unique case (st_q)
				ST_CS: begin
					best_cs_q <= pick_cs;
					if (better) best_d_q <= g_dist;
					if (cs_q == CS_LAST) begin
						cs_q <= pick_cs;
						st_q <= ST_COMP;
					end else
						cs_q <= cs_q + 3'h1;
				end
				ST_COMP: begin
					if (in_upper || comp_q == COMP_MAX) begin
						st_q    <= ST_AVG;
						avg_n_q <= '0;
						sum_q   <= '0;
					end else
						comp_q <= comp_q + 1'b1;
				end
				ST_AVG: begin
					sum_q   <= sum_nx;
					avg_n_q <= avg_n_q + 6'h01;
					if (avg_n_q == AVG_LAST) begin
						ref_q <= avg_val[CW-1:0];
						st_q  <= ST_RUN;
					end
				end
				ST_RUN: ;
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			last_q  <= '0;
			prox_q  <= 1'b0;
			touch_q <= 1'b0;
		end else begin
			if (b_done) last_q <= b_cnt;
			if (tuning || retune) begin
				prox_q  <= 1'b0;
				touch_q <= 1'b0;
			end else if (run_done) begin
				prox_q  <= prox_nx;
				touch_q <= touch_nx;
			end
		end
	end

	assign ev[CBT_I_TUNED] = (st_q == ST_AVG) && b_done && avg_n_q == AVG_LAST;
	assign ev[CBT_I_PROX]  = run_done && !retune && prox_nx && !prox_q;
	assign ev[CBT_I_TOUCH] = run_done && !retune && touch_nx && !touch_q;
	assign ev[CBT_I_SAT]   = b_done && b_sat;

	// compensation found by tuning stays applied on every acquisition until a retune clears it to zero
	assign cs_sel                 = cs_q;
	assign parasitic_compensation = comp_q;

	// =====================================================
	// pins
	wire det_any = prox_q || touch_q;
	wire pri_val = (mode == CBT_MODE_DUAL) ? touch_q :
	               (mode == CBT_MODE_STREAM) ? tuning : det_any;
	wire pri_od  = !pp || (mode == CBT_MODE_STREAM);
	wire dual    = (mode == CBT_MODE_DUAL);

	// open drain pulls low for an active indication; the bus pull-up gives idle high
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			primary_o    <= 1'b1;
			primary_oe   <= 1'b0;
			secondary_o  <= 1'b0;
			secondary_oe <= 1'b0;
		end else begin
			primary_o    <= pri_od ? 1'b0 : pri_val;
			primary_oe   <= pri_od ? pri_val : 1'b1;
			secondary_o  <= dual && prox_q && !touch_q;
			secondary_oe <= dual;
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (haddr[7:0] & 8'hFC)
			CBT_A_CTRL:   rd_mux = {26'h0, ctrl_q & 6'h2F};
			CBT_A_TARGET: rd_mux = {16'h0, target_q};
			CBT_A_PROX:   rd_mux = {16'h0, prox_th_q};
			CBT_A_TOUCH:  rd_mux = {16'h0, touch_th_q};
			CBT_A_STATUS: rd_mux = {16'h0, comp_q, 1'b0, cs_q, 1'b0, touch_q, prox_q, tuning};
			CBT_A_COUNT:  rd_mux = {ref_q, last_q};
			CBT_A_IRQ_ST: rd_mux = {28'h0, ist_q};
			CBT_A_IRQ_EN: rd_mux = {28'h0, ien_q};
			default:      rd_mux = 32'h0000_0000;
		endcase
	end

	// =====================================================
	// checks
	sequence avg_last_s;
		st_q == ST_AVG && b_done && avg_n_q == AVG_LAST && !retune;
	endsequence

	no_report_tune_a: assert property (@(posedge hclk) disable iff (!hresetn)
		tuning |=> !prox_q && !touch_q)
		else $error("detection reported while tuning");
	avg_to_run_a: assert property (@(posedge hclk) disable iff (!hresetn)
		avg_last_s |=> st_q == ST_RUN && ref_q == $past(avg_val[CW-1:0]))
		else $error("reference not formed from average");
	retune_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
		retune |=> st_q == ST_CS && cs_q == 3'h0 && comp_q == '0)
		else $error("retune did not restart capacitor scan");
	comp_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
		st_q == ST_COMP && b_done && !retune && !in_upper && comp_q != COMP_MAX
		|=> comp_q == $past(comp_q) + 1'b1)
		else $error("compensation did not step up");
	comp_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
		st_q == ST_RUN && !retune |=> $stable(comp_q) && $stable(cs_q))
		else $error("compensation changed in normal operation");
	prox_det_a: assert property (@(posedge hclk) disable iff (!hresetn)
		run_done && !retune |=> prox_q == $past(prox_nx))
		else $error("proximity not tracking reference minus signal");
	tick_rate_a: assert property (@(posedge hclk) disable iff (!hresetn)
		tick |=> !tick [*8])
		else $error("sequencing tick too fast");
	stream_od_a: assert property (@(posedge hclk) disable iff (!hresetn)
		mode == CBT_MODE_STREAM |=> !primary_o)
		else $error("stream output driven high");
	dual_sec_a: assert property (@(posedge hclk) disable iff (!hresetn)
		dual |=> secondary_oe)
		else $error("proximity pin not driven in dual mode");
	irq_level_a: assert property (@(posedge hclk) disable iff (!hresetn)
		|(ev & ien_q) |=> irq)
		else $error("enabled event did not raise interrupt");
endmodule // cbt_tuning

// ==== verif/cbt_electrode_model.sv ====
module cbt_electrode_model
	import cbt_pkg::*;
#(
	parameter logic [63:0] BASE = 64'h0203_0604_0702_0503
) (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  transfer_on,
	input  wire logic [2:0]            cs_sel,
	input  wire logic [CBT_COMP_W-1:0] comp,
	input  wire logic [7:0]            drop,
	output logic                       trip_level
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] n_q;
	logic       xfr_q;
	logic [7:0] need;
	int         raw;
	// =====================================================
	// transfers needed: small counts keep bursts short; a hand or more compensation trips sooner
	assign raw  = int'(BASE[cs_sel*8 +: 8]) - int'(comp) - int'(drop);
	assign need = (raw < 1) ? 8'h01 : raw[7:0];
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			n_q   <= 8'h00;
			xfr_q <= 1'b0;
		end else begin
			xfr_q <= transfer_on;
			if (transfer_on && !xfr_q) begin
				n_q <= n_q + 8'h01;
			end else if (!transfer_on && xfr_q && n_q >= need) begin
				n_q <= 8'h00;
			end
		end
	end
	// comparator is high only while the charged sampling cap is held; it falls once released
	assign trip_level = transfer_on && (n_q >= need);
endmodule // cbt_electrode_model

// ==== verif/tb_capacitive_burst_tuning.sv ====
module tb_capacitive_burst_tuning
	import cbt_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [63:0] BASE   = 64'h0203_0604_0702_0503;
	localparam logic [7:0]  A_NONE = 8'h30;
	logic                  hclk = 1'b0;
	logic                  hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0]           haddr, hwdata, hrdata;
	logic [1:0]            htrans;
	logic [2:0]            hsize, cs_sel, exp_cs;
	logic                  trip_level, charge_on, transfer_on, irq, host_ctrl;
	logic [CBT_COMP_W-1:0] parasitic_compensation;
	logic                  primary_o, primary_oe, secondary_i, secondary_o, secondary_oe;
	logic [7:0]            drop, bv;
	int                    miscompares, num_checks;
	always #12.5 hclk = ~hclk;
	assign hready      = hreadyout;
	assign secondary_i = secondary_oe ? secondary_o : host_ctrl;
	cbt_tuning dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .trip_level(trip_level), .charge_on(charge_on),
		.transfer_on(transfer_on), .cs_sel(cs_sel), .parasitic_compensation(parasitic_compensation),
		.primary_o(primary_o), .primary_oe(primary_oe), .secondary_i(secondary_i),
		.secondary_o(secondary_o), .secondary_oe(secondary_oe), .irq(irq));
	cbt_electrode_model #(.BASE(BASE)) u_elec (.clk(hclk), .rst_n(hresetn), .transfer_on(transfer_on),
		.cs_sel(cs_sel), .comp(parasitic_compensation), .drop(drop), .trip_level(trip_level));
	// =====================================================
	// reporting and bus master
	task automatic final_report();
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask
	task automatic edge_rdy();
		int k;
		k = 0;
		do begin
			@(posedge hclk);
			k++;
		end while (hready !== 1'b1 && k < 50);
		if (hready !== 1'b1) begin
			chk(32'h0, 32'h1, "bus wait timed out");
			final_report();
		end
	endtask
	task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		haddr  <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= we;
		edge_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		edge_rdy();
		q = hrdata;
		chk({31'h0, hresp}, 32'h0, "okay response");
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		bus(1'b0, a, 32'h0, q);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v, input string s);
		logic [31:0] q;
		rd(a, q);
		chk(q & m, v, s);
	endtask
	// status bits may take a few bursts to settle, so read until they match or the bound runs out
	task automatic poll(input logic [31:0] m, input logic [31:0] v);
		logic [31:0] q;
		int          k;
		k = 0;
		do begin
			rd(CBT_A_STATUS, q);
			k++;
		end while ((q & m) !== v && k < 400);
		chk(q & m, v, "status poll");
	endtask
	task automatic wait_irq();
		int k;
		k = 0;
		while (irq !== 1'b1 && k < 40000) begin
			@(posedge hclk);
			k++;
		end
		if (irq !== 1'b1) begin
			chk(32'h0, 32'h1, "interrupt wait timed out");
			final_report();
		end
	endtask
	task automatic pins(input logic [3:0] m, input logic [3:0] v, input string s);
		repeat (2) @(posedge hclk);
		chk({28'h0, {primary_oe, primary_o, secondary_oe, secondary_o} & m}, {28'h0, v}, s);
	endtask
	// =====================================================
	// scenarios
	task automatic t_reset();
		rd_chk(CBT_A_CTRL, 32'hFFFF_FFFF, {26'h0, CBT_CTRL_RST}, "ctrl reset");
		rd_chk(CBT_A_TARGET, 32'hFFFF_FFFF, {16'h0, CBT_TARGET_RST}, "target reset");
		rd_chk(CBT_A_PROX, 32'hFFFF_FFFF, {16'h0, CBT_PROX_RST}, "prox reset");
		rd_chk(CBT_A_TOUCH, 32'hFFFF_FFFF, {16'h0, CBT_TOUCH_RST}, "touch reset");
		wr(A_NONE, 32'hFFFF_FFFF);
		rd_chk(A_NONE, 32'hFFFF_FFFF, 32'h0, "unmapped");
		rd_chk(CBT_A_STATUS, 32'h7, 32'h1, "tuning at startup");
		pins(4'hA, 4'h0, "pins idle while tuning");
		wr(CBT_A_PROX, 32'h1);
		wr(CBT_A_TOUCH, 32'h3);
		wr(CBT_A_IRQ_EN, 32'h1);
		// the model's counts are tiny: a low target keeps the reference inside the window
		wr(CBT_A_TARGET, 32'h0000_0080);
		rd_chk(CBT_A_PROX, 32'hFFFF_FFFF, 32'h1, "prox readback");
		$display("test reset done");
	endtask
	task automatic t_tune();
		logic seen;
		int   k;
		k    = 0;
		seen = 1'b0;
		while (transfer_on === 1'b1 && k < 100) begin
			@(posedge hclk);
			k++;
		end
		k = 0;
		while (transfer_on !== 1'b1 && k < 200) begin
			seen = charge_on;
			@(posedge hclk);
			k++;
		end
		k = 0;
		while (transfer_on === 1'b1 && k < 100) begin
			@(posedge hclk);
			k++;
		end
		chk(32'(k), 32'(CBT_SEQ_DIV), "transfer period");
		chk({31'h0, seen}, 32'h1, "charge before transfer");
		wait_irq();
		rd_chk(CBT_A_STATUS, 32'hFF71, {24'h0, 1'b0, exp_cs, 4'h0}, "tuned status");
		chk({29'h0, cs_sel}, {29'h0, exp_cs}, "cs pin");
		chk({24'h0, parasitic_compensation}, 32'h0, "comp pin");
		rd_chk(CBT_A_COUNT, 32'hFFFF_FFFF, {8'h0, bv, 8'h0, bv}, "reference and count");
		rd_chk(CBT_A_IRQ_ST, 32'hF, 32'h1, "tuned event");
		wr(CBT_A_IRQ_CL, 32'h1);
		rd_chk(CBT_A_IRQ_ST, 32'hF, 32'h0, "event cleared");
		chk({31'h0, irq}, 32'h0, "irq low after clear");
		wr(CBT_A_IRQ_EN, 32'h3);
		$display("test tune done");
	endtask
	task automatic t_detect();
		drop <= 8'd2;
		poll(32'h6, 32'h2);
		pins(4'hC, 4'h8, "control combined");
		chk({31'h0, irq}, 32'h1, "prox irq");
		wr(CBT_A_IRQ_CL, 32'h2);
		rd_chk(CBT_A_IRQ_ST, 32'h2, 32'h0, "prox cleared");
		chk({31'h0, irq}, 32'h0, "irq low");
		wr(CBT_A_CTRL, {30'h0, CBT_MODE_DUAL});
		pins(4'hB, 4'h3, "dual prox only");
		drop <= 8'd4;
		poll(32'h4, 32'h4);
		pins(4'hC, 4'h8, "dual touch open drain");
		rd_chk(CBT_A_IRQ_ST, 32'h4, 32'h4, "touch event");
		chk({31'h0, irq}, 32'h0, "touch masked");
		wr(CBT_A_CTRL, 32'h21);
		pins(4'hC, 4'hC, "dual touch push pull");
		$display("test detect done");
	endtask
	task automatic t_stream();
		int k;
		k = 0;
		wr(CBT_A_CTRL, 32'h22);
		pins(4'h8, 4'h0, "stream idle");
		wr(CBT_A_CTRL, 32'h20);
		host_ctrl <= 1'b1;
		poll(32'h1, 32'h1);
		// let the scan move past capacitor 1 so that a restart is visible
		while (cs_sel < 3'h2 && k < 2000) begin
			@(posedge hclk);
			k++;
		end
		chk({31'h0, cs_sel >= 3'h2}, 32'h1, "scan advancing");
		wr(CBT_A_CTRL, 32'h32);
		rd_chk(CBT_A_STATUS, 32'h7, 32'h1, "retune suppresses");
		chk({31'h0, cs_sel < 3'h2}, 32'h1, "scan restarted");
		drop <= 8'd0;
		pins(4'hC, 4'h8, "stream tuning low");
		wait_irq();
		rd_chk(CBT_A_STATUS, 32'h71, {25'h0, exp_cs, 4'h0}, "retuned");
		pins(4'h8, 4'h0, "stream released");
		$display("test stream done");
	endtask
	// the default target puts the settled reference far below the window
	task automatic t_window();
		wr(CBT_A_TARGET, 32'h0000_0500);
		poll(32'h1, 32'h1);
		$display("test window done");
	endtask
	// =====================================================
	// main sequence
	initial begin
		int d;
		int best;
		hresetn     = 1'b0;
		hsel        = 1'b1;
		haddr       = 32'h0;
		htrans      = 2'h0;
		hwrite      = 1'b0;
		hsize       = 3'h2;
		hwdata      = 32'h0;
		drop        = 8'h00;
		host_ctrl   = 1'b0;
		miscompares = 0;
		num_checks  = 0;
		exp_cs      = 3'h0;
		best        = 1 << 20;
		for (int i = 0; i < 8; i++) begin
			d = int'(CBT_GAIN_0) - int'(BASE[i*8 +: 8]);
			if (d < 0) d = -d;
			if (d < best) begin
				best   = d;
				exp_cs = i[2:0];
			end
		end
		bv = BASE[exp_cs*8 +: 8];
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_tune();
		t_detect();
		t_stream();
		t_window();
		final_report();
	end
endmodule // tb_capacitive_burst_tuning
